// File: hw/pdsl_pkg.sv
/*
 * Constants for the device status / link capability / link control register slice.
 * Assumes one 100 MHz clock domain and a synchronous active-low reset.
 */
// Contract
// - Four error-detected flags set on events regardless of enables; reset zero; write-one clears
// - Aux-power-detected flag at status bit 20, read-only, resets to one
// - Pending, completion-boundary, link-disable, retrain and port number read zero
// - Max link speed bits 3:0 read-only, reset 0001b (2.5 Gb/s)
// - Max link width bits 9:4 read-only, reports single lane
// - ASPM support bits 11:10 read-only, reset 11b (L0s and L1)
// - L0s exit latency bits 14:12 reset 011b (256 ns to 512 ns)
// - L1 exit latency bits 17:15 reset 000b (16 us to 32 us)
// - ASPM support and exit latency reset values replaceable by EEPROM autoload
// - ASPM control bits 1:0 writable, reset 00b, encodings off/L0s/L1/both
// - Receiver may enter L0s even with ASPM control disabled
// - Common clock configuration bit 6 writable, reset 0
// - Extended synch bit 7: send 4096 FTS from L0s, 1024 TS1 from L1
// - Error reporting enables in control bits 3:0, reset zero, gate reporting only
package pdsl_pkg;
	// -------------------------------------------------------------
	// Register map (byte addresses)
	// -------------------------------------------------------------
	localparam logic [7:0] PDSL_OFS_DEV = 8'he8;
	localparam logic [7:0] PDSL_OFS_LCAP = 8'hec;
	localparam logic [7:0] PDSL_OFS_LCTL = 8'hf0;
	localparam logic [7:0] PDSL_OFS_IRQ_STAT = 8'hf4;
	localparam logic [7:0] PDSL_OFS_IRQ_MASK = 8'hf8;
	localparam logic [7:0] PDSL_OFS_LINK_EVT = 8'hfc;
	// -------------------------------------------------------------
	// Field positions and reset values
	// -------------------------------------------------------------
	localparam int PDSL_ERR_LSB = 16;
	localparam int PDSL_AUX_BIT = 20;
	localparam int PDSL_SPD_LSB = 0;
	localparam int PDSL_WID_LSB = 4;
	localparam int PDSL_ASPMS_LSB = 10;
	localparam int PDSL_L0S_LSB = 12;
	localparam int PDSL_L1_LSB = 15;
	localparam int PDSL_CCC_BIT = 6;
	localparam int PDSL_XSYNC_BIT = 7;
	localparam logic PDSL_AUX_RST = 1'h1;
	localparam logic [3:0] PDSL_SPD_RST = 4'h1;
	localparam logic [5:0] PDSL_WID_RST = 6'h01;
	localparam logic [1:0] PDSL_ASPMS_RST = 2'h3;
	localparam logic [2:0] PDSL_L0S_RST = 3'h3;
	localparam logic [2:0] PDSL_L1_RST = 3'h0;
	localparam logic [1:0] PDSL_ASPMC_RST = 2'h0;
	// ASPM control encodings
	localparam logic [1:0] PDSL_ASPM_OFF = 2'h0;
	localparam logic [1:0] PDSL_ASPM_L0S = 2'h1;
	localparam logic [1:0] PDSL_ASPM_L1 = 2'h2;
	localparam logic [1:0] PDSL_ASPM_BOTH = 2'h3;
	// Ordered-set counts on exit from low-power states
	localparam logic [12:0] PDSL_FTS_EXT = 13'h1000;
	localparam logic [12:0] PDSL_TS1_EXT = 13'h0400;
	localparam logic [7:0] PDSL_FTS_NORM = 8'h80;
	localparam logic [12:0] PDSL_TS1_NORM = 13'h0010;
	// AXI responses
	localparam logic [1:0] PDSL_RESP_OKAY = 2'h0;
	localparam logic [1:0] PDSL_RESP_SLVERR = 2'h2;
endpackage : pdsl_pkg

// File: hw/pdsl_reg_if.sv
/*
 * Internal register access carrier between the AXI slave and the register bank.
 * Assumes both sides share aclk.
 */
`timescale 1ns/1ps
interface pdsl_reg_if;
	logic wr_en;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_err;
	logic rd_en;
	logic [7:0] rd_addr;
	logic [31:0] rd_data;
	logic rd_err;
	modport slave(output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
		input wr_err, rd_data, rd_err);
	modport bank(input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
		output wr_err, rd_data, rd_err);
endinterface : pdsl_reg_if

// File: hw/pdsl_axi_slave.sv
/*
 * AXI4-Lite slave: takes AW and W in either order, one write and one read at a time.
 * Assumes the bank answers writes and reads combinationally in the same cycle.
 */
`timescale 1ns/1ps
module pdsl_axi_slave import pdsl_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	pdsl_reg_if.slave rif
);
	logic aw_hold, w_hold, next_aw_hold, next_w_hold;
	logic [7:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic next_bvalid, next_rvalid;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] next_rdata;

	// -------------------------------------------------------------
	// Write and read channel next state
	// -------------------------------------------------------------
	always_comb begin
		next_aw_hold = aw_hold;
		next_w_hold = w_hold;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_rvalid = rvalid;
		next_rresp = rresp;
		next_rdata = rdata;
		rif.wr_en = 1'b0;
		rif.rd_en = 1'b0;
		if (awvalid && awready) begin
			next_aw_hold = 1'b1;
			next_aw_addr = awaddr;
		end
		if (wvalid && wready) begin
			next_w_hold = 1'b1;
			next_w_data = wdata;
			next_w_strb = wstrb;
		end
		// Commit only once both halves are held, so order of arrival does not matter
		if (aw_hold && w_hold && !bvalid) begin
			rif.wr_en = 1'b1;
			next_aw_hold = 1'b0;
			next_w_hold = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = rif.wr_err ? PDSL_RESP_SLVERR : PDSL_RESP_OKAY;
		end
		if (bvalid && bready) begin
			next_bvalid = 1'b0;
		end
		if (arvalid && arready) begin
			rif.rd_en = 1'b1;
			next_rvalid = 1'b1;
			next_rdata = rif.rd_data;
			next_rresp = rif.rd_err ? PDSL_RESP_SLVERR : PDSL_RESP_OKAY;
		end else if (rvalid && rready) begin
			next_rvalid = 1'b0;
		end
	end

	assign rif.wr_addr = aw_addr;
	assign rif.wr_data = w_data;
	assign rif.wr_strb = w_strb;
	assign rif.rd_addr = araddr;

	// -------------------------------------------------------------
	// Registers
	// -------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= PDSL_RESP_OKAY;
			rvalid <= 1'b0;
			rresp <= PDSL_RESP_OKAY;
			rdata <= 32'h0000_0000;
			awready <= 1'b0;
			wready <= 1'b0;
			arready <= 1'b0;
		end else begin
			aw_hold <= next_aw_hold;
			w_hold <= next_w_hold;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rresp <= next_rresp;
			rdata <= next_rdata;
			// Ready is registered; deasserted the cycle a beat is taken
			awready <= !next_aw_hold && !next_bvalid && !(awvalid && awready);
			wready <= !next_w_hold && !next_bvalid && !(wvalid && wready);
			arready <= !next_rvalid && !(arvalid && arready);
		end
	end
endmodule : pdsl_axi_slave

// File: hw/pdsl_os_sender.sv
/*
 * Counts ordered sets sent when the link leaves L0s or L1 for L0.
 * Assumes the PHY pulses os_sent once per ordered set transmitted.
 */
`timescale 1ns/1ps
module pdsl_os_sender import pdsl_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ext_sync,
	input wire logic exit_l0s,
	input wire logic exit_l1,
	input wire logic os_sent,
	output logic send_fts,
	output logic send_ts1,
	output logic done
);
	typedef enum logic [1:0] {
		PDSL_OS_IDLE = 2'b00,
		PDSL_OS_FTS = 2'b01,
		PDSL_OS_TS1 = 2'b10
	} pdsl_os_e;
	pdsl_os_e state, next_state;
	logic [12:0] left, next_left;
	logic next_done;

	// -------------------------------------------------------------
	// Burst sequencer
	// -------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_left = left;
		next_done = 1'b0;
		case (state)
			PDSL_OS_IDLE: begin
				// Extended synch picks the long counts; latched at the exit request
				if (exit_l0s) begin
					next_state = PDSL_OS_FTS;
					next_left = ext_sync ? PDSL_FTS_EXT : {5'h00, PDSL_FTS_NORM};
				end else if (exit_l1) begin
					next_state = PDSL_OS_TS1;
					next_left = ext_sync ? PDSL_TS1_EXT : PDSL_TS1_NORM;
				end
			end
			PDSL_OS_FTS, PDSL_OS_TS1: begin
				if (os_sent) begin
					next_left = left - 13'h0001;
					if (left == 13'h0001) begin
						next_state = PDSL_OS_IDLE;
						next_done = 1'b1;
					end
				end
			end
			default: next_state = PDSL_OS_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= PDSL_OS_IDLE;
			left <= 13'h0000;
			done <= 1'b0;
			send_fts <= 1'b0;
			send_ts1 <= 1'b0;
		end else begin
			state <= next_state;
			left <= next_left;
			done <= next_done;
			send_fts <= (next_state == PDSL_OS_FTS);
			send_ts1 <= (next_state == PDSL_OS_TS1);
		end
	end
endmodule : pdsl_os_sender

// File: hw/pdsl_regs.sv
/*
 * Device status, link capabilities and link control registers over AXI4-Lite,
 * with error-reporting enables, sticky interrupt status and ordered-set sequencing.
 * Assumes error, aux-power and link event inputs are synchronous to aclk and
 * that EEPROM autoload data is held stable while eeprom_load pulses.
 */
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module pdsl_regs import pdsl_pkg::*; #(
	parameter logic [5:0] MAX_WIDTH = PDSL_WID_RST
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [3:0] err_event,
	input wire logic aux_power_present,
	input wire logic eeprom_load,
	input wire logic [1:0] eeprom_aspm_support,
	input wire logic [2:0] eeprom_l0s_latency,
	input wire logic [2:0] eeprom_l1_latency,
	input wire logic exit_l0s,
	input wire logic exit_l1,
	input wire logic os_sent,
	output logic [3:0] err_report,
	output logic [1:0] aspm_control,
	output logic l0s_entry_allowed,
	output logic l1_entry_allowed,
	output logic rx_l0s_allowed,
	output logic common_clock,
	output logic send_fts,
	output logic send_ts1,
	output logic irq
);
	pdsl_reg_if rif();

	// Register state
	logic [3:0] err_det, next_err_det;
	logic aux_det, next_aux_det;
	logic [1:0] aspm_sup, next_aspm_sup;
	logic [2:0] l0s_lat, next_l0s_lat;
	logic [2:0] l1_lat, next_l1_lat;
	logic [3:0] rep_en, next_rep_en;
	logic [1:0] aspm_ctl, next_aspm_ctl;
	logic ccc, next_ccc;
	logic xsync, next_xsync;
	logic [4:0] irq_stat, next_irq_stat;
	logic [4:0] irq_mask, next_irq_mask;
	logic os_done;
	logic [31:0] dev_word, lcap_word, lctl_word;
	logic [31:0] wmask;
	logic [4:0] irq_evt;
	logic os_fts, os_ts1;

	// -------------------------------------------------------------
	// Bus slave and ordered-set sequencer
	// -------------------------------------------------------------
	pdsl_axi_slave u_axi (
		.aclk(aclk),
		.aresetn(aresetn),
		.awaddr(s_axi_awaddr),
		.awvalid(s_axi_awvalid),
		.awready(s_axi_awready),
		.wdata(s_axi_wdata),
		.wstrb(s_axi_wstrb),
		.wvalid(s_axi_wvalid),
		.wready(s_axi_wready),
		.bresp(s_axi_bresp),
		.bvalid(s_axi_bvalid),
		.bready(s_axi_bready),
		.araddr(s_axi_araddr),
		.arvalid(s_axi_arvalid),
		.arready(s_axi_arready),
		.rdata(s_axi_rdata),
		.rresp(s_axi_rresp),
		.rvalid(s_axi_rvalid),
		.rready(s_axi_rready),
		.rif(rif)
	);

	pdsl_os_sender u_os (
		.aclk(aclk),
		.aresetn(aresetn),
		.ext_sync(xsync),
		.exit_l0s(exit_l0s),
		.exit_l1(exit_l1),
		.os_sent(os_sent),
		.send_fts(os_fts),
		.send_ts1(os_ts1),
		.done(os_done)
	);

	// -------------------------------------------------------------
	// Read words
	// -------------------------------------------------------------
	// Unimplemented and reserved fields are left as constant zero
	always_comb begin
		dev_word = 32'h0000_0000;
		dev_word[3:0] = rep_en;
		dev_word[PDSL_ERR_LSB +: 4] = err_det;
		dev_word[PDSL_AUX_BIT] = aux_det;
		lcap_word = 32'h0000_0000;
		lcap_word[PDSL_SPD_LSB +: 4] = PDSL_SPD_RST;
		lcap_word[PDSL_WID_LSB +: 6] = MAX_WIDTH;
		lcap_word[PDSL_ASPMS_LSB +: 2] = aspm_sup;
		lcap_word[PDSL_L0S_LSB +: 3] = l0s_lat;
		lcap_word[PDSL_L1_LSB +: 3] = l1_lat;
		lctl_word = 32'h0000_0000;
		lctl_word[1:0] = aspm_ctl;
		lctl_word[PDSL_CCC_BIT] = ccc;
		lctl_word[PDSL_XSYNC_BIT] = xsync;
	end

	always_comb begin
		rif.rd_err = 1'b0;
		case (rif.rd_addr)
			PDSL_OFS_DEV: rif.rd_data = dev_word;
			PDSL_OFS_LCAP: rif.rd_data = lcap_word;
			PDSL_OFS_LCTL: rif.rd_data = lctl_word;
			PDSL_OFS_IRQ_STAT: rif.rd_data = {27'h0000000, irq_stat};
			PDSL_OFS_IRQ_MASK: rif.rd_data = {27'h0000000, irq_mask};
			default: begin
				rif.rd_data = 32'h0000_0000;
				rif.rd_err = 1'b1;
			end
		endcase
	end

	// Byte-lane mask from write strobes
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			wmask[8*i +: 8] = {8{rif.wr_strb[i]}};
		end
	end

	// -------------------------------------------------------------
	// Register next state
	// -------------------------------------------------------------
	always_comb begin
		next_err_det = err_det;
		next_aux_det = aux_power_present;
		next_aspm_sup = aspm_sup;
		next_l0s_lat = l0s_lat;
		next_l1_lat = l1_lat;
		next_rep_en = rep_en;
		next_aspm_ctl = aspm_ctl;
		next_ccc = ccc;
		next_xsync = xsync;
		next_irq_stat = irq_stat;
		next_irq_mask = irq_mask;
		rif.wr_err = 1'b0;
		if (rif.wr_en) begin
			case (rif.wr_addr)
				PDSL_OFS_DEV: begin
					next_rep_en = (rep_en & ~wmask[3:0]) | (rif.wr_data[3:0] & wmask[3:0]);
					next_err_det = err_det & ~(rif.wr_data[PDSL_ERR_LSB +: 4]
						& wmask[PDSL_ERR_LSB +: 4]);
				end
				PDSL_OFS_LCAP: ; // Read-only: write accepted and dropped
				PDSL_OFS_LCTL: begin
					if (rif.wr_strb[0]) begin
						next_aspm_ctl = rif.wr_data[1:0];
						next_ccc = rif.wr_data[PDSL_CCC_BIT];
						next_xsync = rif.wr_data[PDSL_XSYNC_BIT];
					end
				end
				PDSL_OFS_IRQ_STAT: next_irq_stat = irq_stat & ~(rif.wr_data[4:0] & wmask[4:0]);
				PDSL_OFS_IRQ_MASK: next_irq_mask = (irq_mask & ~wmask[4:0])
					| (rif.wr_data[4:0] & wmask[4:0]);
				default: rif.wr_err = 1'b1;
			endcase
		end
		// Hardware set after the clear so a same-cycle event is never lost
		next_err_det = next_err_det | err_event;
		next_irq_stat = next_irq_stat | irq_evt;
		// Autoload overrides the strapped capability defaults
		if (eeprom_load) begin
			next_aspm_sup = eeprom_aspm_support;
			next_l0s_lat = eeprom_l0s_latency;
			next_l1_lat = eeprom_l1_latency;
		end
	end

	assign irq_evt = {os_done, err_event};

	// -------------------------------------------------------------
	// Registers and outputs
	// -------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			err_det <= 4'h0;
			aux_det <= PDSL_AUX_RST;
			aspm_sup <= PDSL_ASPMS_RST;
			l0s_lat <= PDSL_L0S_RST;
			l1_lat <= PDSL_L1_RST;
			rep_en <= 4'h0;
			aspm_ctl <= PDSL_ASPMC_RST;
			ccc <= 1'b0;
			xsync <= 1'b0;
			irq_stat <= 5'h00;
			irq_mask <= 5'h00;
			err_report <= 4'h0;
			aspm_control <= PDSL_ASPMC_RST;
			l0s_entry_allowed <= 1'b0;
			l1_entry_allowed <= 1'b0;
			rx_l0s_allowed <= 1'b1;
			common_clock <= 1'b0;
			send_fts <= 1'b0;
			send_ts1 <= 1'b0;
			irq <= 1'b0;
		end else begin
			err_det <= next_err_det;
			aux_det <= next_aux_det;
			aspm_sup <= next_aspm_sup;
			l0s_lat <= next_l0s_lat;
			l1_lat <= next_l1_lat;
			rep_en <= next_rep_en;
			aspm_ctl <= next_aspm_ctl;
			ccc <= next_ccc;
			xsync <= next_xsync;
			irq_stat <= next_irq_stat;
			irq_mask <= next_irq_mask;
			// Enables gate only the report, never the logging above
			err_report <= err_event & next_rep_en;
			aspm_control <= next_aspm_ctl;
			l0s_entry_allowed <= next_aspm_ctl[0];
			l1_entry_allowed <= next_aspm_ctl[1];
			rx_l0s_allowed <= 1'b1;
			common_clock <= next_ccc;
			send_fts <= os_fts;
			send_ts1 <= os_ts1;
			irq <= |(next_irq_stat & next_irq_mask);
		end
	end
endmodule : pdsl_regs

// File: tb/pdsl_chk.sv
/*
 * Port checker for the register slice.
 * Assumes it is bound to pdsl_regs and sees one clock domain.
 */
`timescale 1ns/1ps
module pdsl_chk import pdsl_pkg::*; #(
	parameter logic [5:0] MAX_WIDTH = PDSL_WID_RST
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] err_event,
	input wire logic [3:0] err_report,
	input wire logic [1:0] aspm_control,
	input wire logic l0s_entry_allowed,
	input wire logic l1_entry_allowed,
	input wire logic rx_l0s_allowed,
	input wire logic send_fts,
	input wire logic send_ts1
);
	// Last read address, so read data is judged per register
	logic [7:0] rd_addr;
	logic [7:0] next_rd_addr;
	always_comb next_rd_addr = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : rd_addr;
	always_ff @(posedge aclk) rd_addr <= aresetn ? next_rd_addr : 8'h00;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_rd_of(logic [7:0] a);
		s_axi_rvalid && rd_addr == a;
	endsequence
	a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid) else $error("read answer late");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_dev_rsvd: assert property (
		s_rd_of(PDSL_OFS_DEV) |-> s_axi_rdata[31:21] == 11'h0 && s_axi_rdata[15:4] == 12'h0)
		else $error("status reserved bits set");
	a_lcap_fixed: assert property (
		s_rd_of(PDSL_OFS_LCAP) |-> s_axi_rdata[3:0] == PDSL_SPD_RST
		&& s_axi_rdata[9:4] == MAX_WIDTH && s_axi_rdata[31:18] == 14'h0)
		else $error("capability fixed fields wrong");
	a_lctl_rsvd: assert property (
		s_rd_of(PDSL_OFS_LCTL) |-> s_axi_rdata[31:8] == 24'h0 && s_axi_rdata[5:2] == 4'h0)
		else $error("control reserved bits set");
	a_lctl_view: assert property (
		s_rd_of(PDSL_OFS_LCTL) |-> s_axi_rdata[1:0] == aspm_control)
		else $error("control readback differs from output");
	a_err_report: assert property (
		err_report != 4'h0 |-> (err_report & ~$past(err_event)) == 4'h0)
		else $error("report without event");
	a_l0s_gate: assert property (l0s_entry_allowed == aspm_control[0])
		else $error("l0s entry mismatch");
	a_l1_gate: assert property (l1_entry_allowed == aspm_control[1])
		else $error("l1 entry mismatch");
	a_rx_l0s: assert property (rx_l0s_allowed) else $error("receiver l0s blocked");
	a_burst_excl: assert property (send_fts |-> !send_ts1) else $error("both bursts");
endmodule : pdsl_chk
bind pdsl_regs pdsl_chk #(.MAX_WIDTH(MAX_WIDTH)) pdsl_chk_inst (.aclk, .aresetn,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .err_event, .err_report, .aspm_control,
	.l0s_entry_allowed, .l1_entry_allowed, .rx_l0s_allowed, .send_fts, .send_ts1);

// File: tb/pdsl_link_model.sv
/*
 * Far-side link partner: sends one ordered set per gap while a burst is requested.
 * Assumes send_fts/send_ts1 levels from pdsl_regs and one clock.
 */
`timescale 1ns/1ps
module pdsl_link_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic send_fts,
	input wire logic send_ts1,
	input wire logic [3:0] gap,
	output logic os_sent,
	output int fts_count,
	output int ts1_count
);
	int idle;
	// Idle gap after each set, since the request levels lag the count
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			os_sent <= 1'b0;
			idle <= 0;
			fts_count <= 0;
			ts1_count <= 0;
		end else if (os_sent) begin
			os_sent <= 1'b0;
			idle <= int'(gap);
		end else if (idle != 0) begin
			idle <= idle - 1;
		end else if (send_fts || send_ts1) begin
			os_sent <= 1'b1;
			if (send_fts) fts_count <= fts_count + 1;
			else ts1_count <= ts1_count + 1;
		end
	end
endmodule : pdsl_link_model

// File: tb/test_pcie_dev_status_link_regs.sv
/*
 * Self-checking bench for pdsl_regs over AXI4-Lite.
 * Assumes pdsl_chk is bound and pdsl_link_model paces ordered sets.
 */
`timescale 1ns/1ps
module test_pcie_dev_status_link_regs import pdsl_pkg::*;;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic [3:0] err_event = 4'h0;
	logic aux = 1'b1;
	logic ee_load = 1'b0;
	logic [1:0] ee_aspm = 2'h0;
	logic [2:0] ee_l0s = 3'h0;
	logic [2:0] ee_l1 = 3'h0;
	logic exit_l0s = 1'b0;
	logic exit_l1 = 1'b0;
	logic [3:0] gap = 4'h5;
	logic awready, wready, bvalid, arready, rvalid, os_sent, l0s_ok, l1_ok, rx_l0s, ccc;
	logic send_fts, send_ts1, irq;
	logic [1:0] bresp, rresp, aspm_control;
	logic [31:0] rdata;
	logic [3:0] err_report;
	int fts_count, ts1_count;
	int fail_count = 0;
	int checked = 0;
	always #5 aclk = ~aclk;
	pdsl_regs pdsl_regs_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.err_event(err_event), .aux_power_present(aux), .eeprom_load(ee_load),
		.eeprom_aspm_support(ee_aspm), .eeprom_l0s_latency(ee_l0s), .eeprom_l1_latency(ee_l1),
		.exit_l0s(exit_l0s), .exit_l1(exit_l1), .os_sent(os_sent), .err_report(err_report),
		.aspm_control(aspm_control), .l0s_entry_allowed(l0s_ok), .l1_entry_allowed(l1_ok),
		.rx_l0s_allowed(rx_l0s), .common_clock(ccc), .send_fts(send_fts),
		.send_ts1(send_ts1), .irq(irq));
	pdsl_link_model pdsl_link_model_inst (.aclk(aclk), .aresetn(aresetn), .send_fts(send_fts),
		.send_ts1(send_ts1), .gap(gap), .os_sent(os_sent), .fts_count(fts_count),
		.ts1_count(ts1_count));
	// ----------------------------------------
	// Shared checks and bus cycles
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : conclude
	// Each half is released at its own handshake edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid && n < 40);
		bready <= 1'b0;
		check({29'h0, bvalid, bresp}, {29'h0, 1'b1, r});
		@(posedge aclk); // Let an edge pass so a following call never re-drives bready at once
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (arready) arvalid <= 1'b0;
		end while (!rvalid && n < 40);
		rready <= 1'b0;
		check(rdata, e);
		check({29'h0, rvalid, rresp}, {29'h0, 1'b1, r});
		@(posedge aclk); // Let an edge pass so a following call never re-drives rready at once
	endtask : rd
	task automatic pulse(input logic [3:0] e);
		err_event <= e;
		@(posedge aclk);
		err_event <= 4'h0;
		@(posedge aclk);
	endtask : pulse
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		rd(PDSL_OFS_DEV, 32'h0010_0000, PDSL_RESP_OKAY);
		rd(PDSL_OFS_LCAP, 32'h0000_3c11, PDSL_RESP_OKAY);
		rd(PDSL_OFS_LCTL, 32'h0, PDSL_RESP_OKAY);
		rd(PDSL_OFS_IRQ_MASK, 32'h0, PDSL_RESP_OKAY);
		rd(8'h00, 32'h0, PDSL_RESP_SLVERR);
		check({28'h0, rx_l0s, irq, aspm_control}, 32'h8);
		$display("test reset done");
	endtask : t_reset
	task automatic t_err();
		logic [31:0] st;
		st = 32'h0010_0000;
		for (int i = 0; i < 4; i++) begin
			pulse(4'h1 << i);
			check({28'h0, err_report}, 32'h0);
			st[16 + i] = 1'b1;
			rd(PDSL_OFS_DEV, st, PDSL_RESP_OKAY);
		end
		wr(PDSL_OFS_DEV, 32'h000a_0000, PDSL_RESP_OKAY);
		rd(PDSL_OFS_DEV, 32'h0015_0000, PDSL_RESP_OKAY);
		wr(PDSL_OFS_DEV, 32'h0005_000f, PDSL_RESP_OKAY);
		pulse(4'h6);
		check({28'h0, err_report}, 32'h6);
		rd(PDSL_OFS_DEV, 32'h0016_000f, PDSL_RESP_OKAY);
		$display("test error flags done");
	endtask : t_err
	task automatic t_rsvd();
		wr(PDSL_OFS_DEV, 32'hffff_fff0, PDSL_RESP_OKAY);
		rd(PDSL_OFS_DEV, 32'h0010_0000, PDSL_RESP_OKAY);
		wr(PDSL_OFS_LCAP, 32'hffff_ffff, PDSL_RESP_OKAY);
		rd(PDSL_OFS_LCAP, 32'h0000_3c11, PDSL_RESP_OKAY);
		wr(PDSL_OFS_LCTL, 32'hffff_ffff, PDSL_RESP_OKAY);
		rd(PDSL_OFS_LCTL, 32'h0000_00c3, PDSL_RESP_OKAY);
		$display("test reserved done");
	endtask : t_rsvd
	task automatic t_aspm();
		for (int c = 0; c < 4; c++) begin
			wr(PDSL_OFS_LCTL, {25'h0, c[0], 4'h0, c[1:0]}, PDSL_RESP_OKAY);
			rd(PDSL_OFS_LCTL, {25'h0, c[0], 4'h0, c[1:0]}, PDSL_RESP_OKAY);
			check({26'h0, rx_l0s, ccc, l1_ok, l0s_ok, aspm_control},
				{26'h0, 1'b1, c[0], c[1], c[0], c[1:0]});
		end
		$display("test aspm done");
	endtask : t_aspm
	task automatic t_load();
		ee_aspm <= 2'h1;
		ee_l0s <= 3'h5;
		ee_l1 <= 3'h6;
		ee_load <= 1'b1;
		@(posedge aclk);
		ee_load <= 1'b0;
		rd(PDSL_OFS_LCAP, 32'h0003_5411, PDSL_RESP_OKAY);
		aux <= 1'b0;
		repeat (3) @(posedge aclk);
		rd(PDSL_OFS_DEV, 32'h0, PDSL_RESP_OKAY);
		aux <= 1'b1;
		$display("test load and aux done");
	endtask : t_load
	task automatic t_irq();
		wr(PDSL_OFS_IRQ_STAT, 32'h1f, PDSL_RESP_OKAY);
		wr(PDSL_OFS_IRQ_MASK, 32'h01, PDSL_RESP_OKAY);
		pulse(4'h2);
		repeat (2) @(posedge aclk);
		check({31'h0, irq}, 32'h0);
		pulse(4'h1);
		repeat (2) @(posedge aclk);
		check({31'h0, irq}, 32'h1);
		rd(PDSL_OFS_IRQ_STAT, 32'h3, PDSL_RESP_OKAY);
		wr(PDSL_OFS_IRQ_STAT, 32'h1, PDSL_RESP_OKAY);
		repeat (3) @(posedge aclk);
		check({31'h0, irq}, 32'h0);
		$display("test interrupt done");
	endtask : t_irq
	// Burst end shows as irq status bit 4; counts come from the far-side model
	task automatic t_burst(input logic [7:0] lctl, input int nf, input int nt);
		int f0;
		int t0;
		wr(PDSL_OFS_IRQ_MASK, 32'h10, PDSL_RESP_OKAY);
		wr(PDSL_OFS_LCTL, {24'h0, lctl}, PDSL_RESP_OKAY);
		for (int k = 0; k < 2; k++) begin
			f0 = fts_count;
			t0 = ts1_count;
			exit_l0s <= (k == 0);
			exit_l1 <= (k == 1);
			@(posedge aclk);
			exit_l0s <= 1'b0;
			exit_l1 <= 1'b0;
			for (int n = 0; n < 40000 && irq !== 1'b1; n++) @(posedge aclk);
			check({31'h0, irq}, 32'h1);
			check(fts_count - f0, k ? 0 : nf);
			check(ts1_count - t0, k ? nt : 0);
			wr(PDSL_OFS_IRQ_STAT, 32'h10, PDSL_RESP_OKAY);
			repeat (3) @(posedge aclk);
		end
		$display("test burst done");
	endtask : t_burst
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset();
		t_err();
		t_rsvd();
		t_aspm();
		t_load();
		t_irq();
		t_burst(8'h80, 4096, 1024);
		gap <= 4'h3;
		t_burst(8'h00, 128, 16);
		conclude();
	end
	// Watchdog: the long bursts take under 0.4 ms
	initial begin
		#1_000_000;
		fail_count++;
		conclude();
	end
endmodule : test_pcie_dev_status_link_regs
